/* File: design/hbc_pkg.sv */
package hbc_pkg;

  // clock and timing
  localparam int unsigned CLK_PERIOD_NS        = 10;
  localparam int unsigned DEAD_TIME_NS         = 500;
  localparam int unsigned DEAD_CYCLES          = (DEAD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned WAKE_RECOVERY_NS     = 50_000;
  localparam int unsigned WAKE_RECOVERY_CYCLES = (WAKE_RECOVERY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned DEAD_CNT_W           = 8;
  localparam int unsigned WAKE_CNT_W           = 16;

  // register byte addresses
  localparam logic [31:0] ADDR_CFG_CH1 = 32'h0000_0000;
  localparam logic [31:0] ADDR_CFG_CH2 = 32'h0000_0004;
  localparam logic [31:0] ADDR_STATUS  = 32'h0000_0008;

  // channel_config_reg fields
  localparam int unsigned CFG_SLEW_LSB   = 12;
  localparam int unsigned CFG_SLEW_MSB   = 14;
  localparam int unsigned CFG_HSREGEN    = 20;
  localparam logic [31:0] CFG_RESET      = 32'h0000_0000;
  localparam logic [31:0] CFG_WRITE_MASK = 32'h0010_7000;

  // status fields
  localparam int unsigned ST_TSD       = 0;
  localparam int unsigned ST_ISD       = 1;
  localparam int unsigned ST_VBAT_UV   = 2;
  localparam int unsigned ST_VCC_UV    = 3;
  localparam int unsigned ST_OPEN_LOAD = 4;
  localparam int unsigned ST_READY     = 5;
  localparam int unsigned ST_COMBINED  = 6;
  localparam int unsigned ST_PWM_C     = 7;
  localparam int unsigned ST_PWM_D     = 8;

  // pin synchroniser width
  localparam int unsigned SYNC_W = 17;

  typedef enum logic [2:0] {
    SLEW_NORMAL  = 3'h0,
    SLEW_SLOWEST = 3'h1,
    SLEW_SLOW2   = 3'h2,
    SLEW_SLOW3   = 3'h3,
    SLEW_SLOW4   = 3'h4,
    SLEW_FAST2   = 3'h5,
    SLEW_FASTEST = 3'h6
  } hbc_slew_t;

  typedef enum logic [1:0] {
    LVL_Z = 2'h0,
    LVL_L = 2'h1,
    LVL_H = 2'h2
  } hbc_level_t;

  typedef enum logic [4:0] {
    LEG_OFF     = 5'b00001,
    LEG_HS      = 5'b00010,
    LEG_LS      = 5'b00100,
    LEG_WAIT_HS = 5'b01000,
    LEG_DEAD    = 5'b10000
  } hbc_leg_state_t;

  typedef struct packed {
    logic tsd;
    logic isd;
    logic vbat_uv;
    logic vcc_uv;
    logic open_load;
  } hbc_fault_t;

  typedef struct packed {
    logic hs_on;
    logic ls_on;
  } hbc_drv_t;

endpackage : hbc_pkg

/* File: design/hbc_leg.sv */
`timescale 1ns/1ps
`default_nettype none
module hbc_leg (
  // clock and reset
  input  wire logic              sys_clk,
  input  wire logic              reset,
  // request
  input  wire hbc_pkg::hbc_level_t target,
  input  wire logic              force_off,
  input  wire logic              hs_off_fb,
  // switch drive
  output hbc_pkg::hbc_drv_t      drv
);
  import hbc_pkg::*;

  hbc_leg_state_t          state;
  hbc_leg_state_t          next_state;
  logic [DEAD_CNT_W-1:0]   dead_cnt;
  logic [DEAD_CNT_W-1:0]   next_dead_cnt;
  hbc_drv_t                next_drv;

  ////////////////////////////////////////////////////////////
  always_comb begin
    next_state    = state;
    next_dead_cnt = '0;
    if (force_off || target == LVL_Z) begin
      next_state = LEG_OFF;
    end else begin
      case (state)
        LEG_OFF, LEG_LS: begin
          if (target == LVL_H) next_state = LEG_DEAD;
          else if (state == LEG_OFF) next_state = LEG_WAIT_HS;
        end
        LEG_HS: begin
          if (target == LVL_L) next_state = LEG_WAIT_HS;
        end
        LEG_WAIT_HS: begin
          // low side waits for the gate monitor, never on a timer
          if (target == LVL_H) next_state = LEG_DEAD;
          else if (hs_off_fb) next_state = LEG_LS;
        end
        LEG_DEAD: begin
          next_dead_cnt = dead_cnt + 1'b1;
          if (target == LVL_L) next_state = LEG_WAIT_HS;
          else if (dead_cnt == DEAD_CNT_W'(DEAD_CYCLES - 1)) next_state = LEG_HS;
        end
        default: next_state = LEG_OFF;
      endcase
    end
    if (next_state != LEG_DEAD) next_dead_cnt = '0;
    next_drv.hs_on = (next_state == LEG_HS);
    next_drv.ls_on = (next_state == LEG_LS);
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      state    <= LEG_OFF;
      dead_cnt <= '0;
      drv      <= '0;
    end else begin
      state    <= next_state;
      dead_cnt <= next_dead_cnt;
      drv      <= next_drv;
    end
  end

endmodule : hbc_leg
`default_nettype wire

/* File: design/hbc_top.sv */
// Design decisions made here: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module hbc_top #(
  parameter int unsigned WAKE_CYCLES = hbc_pkg::WAKE_RECOVERY_CYCLES
) (
  // clock and reset
  input  wire logic               sys_clk,
  input  wire logic               reset,
  // apb slave
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [31:0]        paddr,
  input  wire logic [31:0]        pwdata,
  output logic [31:0]             prdata,
  output logic                    pready,
  output logic                    pslverr,
  // host pins
  input  wire logic               pwm_in_a,
  input  wire logic               pwm_in_b,
  input  wire logic               pwm_in_c,
  input  wire logic               pwm_in_d,
  input  wire logic               drive_enable_hi_ch1,
  input  wire logic               drive_enable_lo_ch1,
  input  wire logic               drive_enable_hi_ch2,
  input  wire logic               drive_enable_lo_ch2,
  input  wire logic               combined_channel_mode,
  input  wire logic               sleep_req,
  // analog monitors
  input  wire hbc_pkg::hbc_fault_t fault_det,
  input  wire logic               hs_gate_off_a,
  input  wire logic               hs_gate_off_b,
  // bridge drive
  output hbc_pkg::hbc_drv_t       bridge_leg_pair_a,
  output hbc_pkg::hbc_drv_t       bridge_leg_pair_b,
  output hbc_pkg::hbc_slew_t      slew_rate_a,
  output hbc_pkg::hbc_slew_t      slew_rate_b
);
  import hbc_pkg::*;

  ////////////////////////////////////////////////////////////
  // pin synchronisers

  logic [SYNC_W-1:0] sync_raw;
  logic [SYNC_W-1:0] sync_meta;
  logic [SYNC_W-1:0] sync_q;

  assign sync_raw = {pwm_in_a, pwm_in_b, pwm_in_c, pwm_in_d,
                     drive_enable_hi_ch1, drive_enable_lo_ch1,
                     drive_enable_hi_ch2, drive_enable_lo_ch2,
                     combined_channel_mode, sleep_req, fault_det,
                     hs_gate_off_a, hs_gate_off_b};

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      sync_meta <= '0;
      sync_q    <= '0;
    end else begin
      sync_meta <= sync_raw;
      sync_q    <= sync_meta;
    end
  end

  logic       s_pwm_a, s_pwm_b, s_pwm_c, s_pwm_d;
  logic       s_en_hi1, s_en_lo1, s_en_hi2, s_en_lo2;
  logic       s_combined, s_sleep;
  hbc_fault_t s_fault;
  logic       s_gate_a, s_gate_b;

  assign {s_pwm_a, s_pwm_b, s_pwm_c, s_pwm_d,
          s_en_hi1, s_en_lo1, s_en_hi2, s_en_lo2,
          s_combined, s_sleep, s_fault, s_gate_a, s_gate_b} = sync_q;

  ////////////////////////////////////////////////////////////
  // sleep recovery and thermal latch

  logic [WAKE_CNT_W-1:0] wake_cnt;
  logic [WAKE_CNT_W-1:0] next_wake_cnt;
  logic                  tsd_lat;
  logic                  next_tsd_lat;
  logic                  ready;
  logic                  tsd_clr;

  assign ready = (wake_cnt == '0) && !s_sleep;

  always_comb begin
    // reload while asleep, count down once released
    if (s_sleep) next_wake_cnt = WAKE_CNT_W'(WAKE_CYCLES);
    else if (wake_cnt != '0) next_wake_cnt = wake_cnt - 1'b1;
    else next_wake_cnt = wake_cnt;
    // set beats clear; no supply term so low battery cannot drop it
    next_tsd_lat = s_fault.tsd | (tsd_lat & ~tsd_clr);
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      wake_cnt <= WAKE_CNT_W'(WAKE_CYCLES);
      tsd_lat  <= 1'b0;
    end else begin
      wake_cnt <= next_wake_cnt;
      tsd_lat  <= next_tsd_lat;
    end
  end

  ////////////////////////////////////////////////////////////
  // apb registers

  logic [31:0] cfg_ch1, cfg_ch2;
  logic [31:0] next_cfg_ch1, next_cfg_ch2;
  logic [31:0] next_prdata;
  logic        next_pslverr;
  logic [31:0] status;
  logic        setup_ph, wr_acc;
  logic        mapped;

  assign setup_ph = psel && !penable;
  assign wr_acc   = psel && penable && pwrite;
  assign pready   = psel && penable;
  assign mapped   = (paddr == ADDR_CFG_CH1) || (paddr == ADDR_CFG_CH2)
                 || (paddr == ADDR_STATUS);
  assign tsd_clr  = wr_acc && (paddr == ADDR_STATUS) && pwdata[ST_TSD];

  always_comb begin
    status               = '0;
    status[ST_TSD]       = tsd_lat;
    status[ST_ISD]       = s_fault.isd;
    status[ST_VBAT_UV]   = s_fault.vbat_uv;
    status[ST_VCC_UV]    = s_fault.vcc_uv;
    status[ST_OPEN_LOAD] = s_fault.open_load;
    status[ST_READY]     = ready;
    status[ST_COMBINED]  = s_combined;
    status[ST_PWM_C]     = s_pwm_c;
    status[ST_PWM_D]     = s_pwm_d;
    next_cfg_ch1 = cfg_ch1;
    next_cfg_ch2 = cfg_ch2;
    if (wr_acc && paddr == ADDR_CFG_CH1) next_cfg_ch1 = pwdata & CFG_WRITE_MASK;
    if (wr_acc && paddr == ADDR_CFG_CH2) next_cfg_ch2 = pwdata & CFG_WRITE_MASK;
    // read data is captured in setup so it leaves a flop
    next_prdata  = prdata;
    next_pslverr = pslverr;
    if (setup_ph) begin
      next_pslverr = !mapped;
      case (paddr)
        ADDR_CFG_CH1: next_prdata = cfg_ch1;
        ADDR_CFG_CH2: next_prdata = cfg_ch2;
        ADDR_STATUS:  next_prdata = status;
        default:      next_prdata = '0;
      endcase
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      cfg_ch1 <= CFG_RESET;
      cfg_ch2 <= CFG_RESET;
      prdata  <= '0;
      pslverr <= 1'b0;
    end else begin
      cfg_ch1 <= next_cfg_ch1;
      cfg_ch2 <= next_cfg_ch2;
      prdata  <= next_prdata;
      pslverr <= next_pslverr;
    end
  end

  ////////////////////////////////////////////////////////////
  // slew decode

  hbc_slew_t next_slew_a, next_slew_b;

  function automatic hbc_slew_t slew_dec(input logic [31:0] cfg);
    logic [2:0] code;
    code = cfg[CFG_SLEW_MSB:CFG_SLEW_LSB];
    // code 111 is unused; fall back to normal rather than guess
    if (code == 3'h7) slew_dec = SLEW_NORMAL;
    else slew_dec = hbc_slew_t'(code);
  endfunction : slew_dec

  always_comb begin
    next_slew_a = slew_dec(cfg_ch1);
    next_slew_b = slew_dec(cfg_ch2);
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      slew_rate_a <= SLEW_NORMAL;
      slew_rate_b <= SLEW_NORMAL;
    end else begin
      slew_rate_a <= next_slew_a;
      slew_rate_b <= next_slew_b;
    end
  end

  ////////////////////////////////////////////////////////////
  // leg targets

  hbc_level_t tgt_a, tgt_b;
  logic       off_all, off_a, off_b;
  logic       hs_regen, regen_phase;

  always_comb begin
    // dual-channel operation is not served here, so pairs stay off
    // raw thermal flag too, so the latch costs no extra cycle of drive
    off_all = tsd_lat | s_fault.tsd | s_fault.isd | s_fault.vbat_uv
            | s_fault.vcc_uv | !ready | !s_combined;
    off_a   = off_all | !s_en_hi1 | s_en_lo1;
    off_b   = off_all | !s_en_hi2 | s_en_lo2;
    hs_regen    = cfg_ch1[CFG_HSREGEN];
    regen_phase = !s_pwm_a && !s_pwm_b;
    // only pwm a and b feed the legs; c and d are status-only
    if (s_pwm_a || (regen_phase && hs_regen)) tgt_a = LVL_H;
    else tgt_a = LVL_L;
    if (s_pwm_b || (regen_phase && hs_regen)) tgt_b = LVL_H;
    else tgt_b = LVL_L;
  end

  hbc_leg u_leg_a (
    .sys_clk   (sys_clk),
    .reset     (reset),
    .target    (tgt_a),
    .force_off (off_a),
    .hs_off_fb (s_gate_a),
    .drv       (bridge_leg_pair_a)
  );

  hbc_leg u_leg_b (
    .sys_clk   (sys_clk),
    .reset     (reset),
    .target    (tgt_b),
    .force_off (off_b),
    .hs_off_fb (s_gate_b),
    .drv       (bridge_leg_pair_b)
  );

endmodule : hbc_top
`default_nettype wire

/* File: tb/hbc_props.sv */
`timescale 1ns/1ps
`default_nettype none
module hbc_props (
  // clock and reset
  input wire logic               sys_clk,
  input wire logic               reset,
  // apb
  input wire logic               psel,
  input wire logic               penable,
  input wire logic               pwrite,
  input wire logic [31:0]        paddr,
  input wire logic [31:0]        pwdata,
  input wire logic               pslverr,
  // pins
  input wire logic               drive_enable_hi_ch1,
  input wire logic               drive_enable_lo_ch1,
  input wire logic               sleep_req,
  input wire hbc_pkg::hbc_fault_t fault_det,
  input wire logic               hs_gate_off_a,
  // drive
  input wire hbc_pkg::hbc_drv_t  bridge_leg_pair_a,
  input wire hbc_pkg::hbc_drv_t  bridge_leg_pair_b,
  input wire hbc_pkg::hbc_slew_t slew_rate_a
);
  import hbc_pkg::*;
  ////////////////////////////////////////
  // counts off cycles of leg a, saturating so long idles never wrap
  logic [7:0] zcnt;
  logic [7:0] next_zcnt;
  wire logic [2:0] wslew = pwdata[14:12];
  wire logic fl = fault_det.tsd | fault_det.isd | fault_det.vbat_uv | fault_det.vcc_uv;
  always_comb begin
    next_zcnt = (bridge_leg_pair_a != 2'h0) ? 8'h00 : zcnt + ((zcnt != 8'hff) ? 8'h01 : 8'h00);
  end
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) zcnt <= 8'h00;
    else zcnt <= next_zcnt;
  end
  ////////////////////////////////////////
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (reset);
  // four cycles allow for pin synchronisers
  a_fault_forces_off: assert property (fl [*4] |-> {bridge_leg_pair_a, bridge_leg_pair_b} == 4'h0)
    else $error("legs driven during fault");
  a_sleep_forces_off: assert property (sleep_req [*4] |-> {bridge_leg_pair_a, bridge_leg_pair_b} == 4'h0)
    else $error("legs driven in sleep");
  a_disable_off: assert property ((!drive_enable_hi_ch1 || drive_enable_lo_ch1) [*4] |-> bridge_leg_pair_a == 2'h0)
    else $error("leg a driven while disabled");
  a_no_shoot_through: assert property (!(bridge_leg_pair_a.hs_on && bridge_leg_pair_a.ls_on))
    else $error("both switches on");
  a_ls_after_gate: assert property ($rose(bridge_leg_pair_a.ls_on) |-> $past(hs_gate_off_a, 2))
    else $error("low side on before gate off seen");
  a_dead_before_hs: assert property ($rose(bridge_leg_pair_a.hs_on) |-> zcnt >= DEAD_CYCLES)
    else $error("high side on without dead time");
  a_slew_follows_cfg: assert property ((psel && penable && pwrite && paddr == ADDR_CFG_CH1) ##2 1 |->
    slew_rate_a == (($past(wslew, 2) == 3'h7) ? 3'h0 : $past(wslew, 2)))
    else $error("slew code not taken");
  a_unmapped_error: assert property ((psel && !penable && paddr > ADDR_STATUS) |=> pslverr)
    else $error("unmapped access not flagged");
  c_ls_on: cover property ($rose(bridge_leg_pair_a.ls_on));
  c_fault: cover property (fl);
  c_hs_regen: cover property ($rose(bridge_leg_pair_b.hs_on));
endmodule : hbc_props
bind hbc_top hbc_props chk_u (.sys_clk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .pslverr,
  .drive_enable_hi_ch1, .drive_enable_lo_ch1, .sleep_req, .fault_det, .hs_gate_off_a,
  .bridge_leg_pair_a, .bridge_leg_pair_b, .slew_rate_a);
`default_nettype wire

/* File: tb/hbc_gate_model.sv */
`timescale 1ns/1ps
`default_nettype none
module hbc_gate_model #(
  parameter int unsigned LAG = 2
) (
  // clock and reset
  input  wire logic              sys_clk,
  input  wire logic              reset,
  // switch drive
  input  wire hbc_pkg::hbc_drv_t pair_a,
  input  wire hbc_pkg::hbc_drv_t pair_b,
  // gate monitor
  output logic                   gate_off_a,
  output logic                   gate_off_b
);
  import hbc_pkg::*;
  ////////////////////////////////////////
  // gate discharge takes LAG cycles, turn-on drops the flag at once
  logic [LAG-1:0] sh_a;
  logic [LAG-1:0] sh_b;
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      sh_a <= '1;
      sh_b <= '1;
    end else begin
      sh_a <= {sh_a[LAG-2:0], !pair_a.hs_on};
      sh_b <= {sh_b[LAG-2:0], !pair_b.hs_on};
    end
  end
  assign gate_off_a = &sh_a && !pair_a.hs_on;
  assign gate_off_b = &sh_b && !pair_b.hs_on;
endmodule : hbc_gate_model
`default_nettype wire

/* File: tb/hbridge_output_control_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module hbridge_output_control_tb_top;
  import hbc_pkg::*;
  logic        sys_clk, reset, psel, penable, pwrite, pready, pslverr, chk;
  logic [31:0] paddr, pwdata, prdata, w;
  logic        pa, pb, pc, pd, eh1, el1, eh2, el2, mode, slp, ga, gb;
  logic [2:0]  xsa, xsb;
  hbc_fault_t  flt;
  hbc_drv_t    la, lb;
  hbc_slew_t   sa, sb;
  int          n_errors, tests_run, cycles, seed;
  logic [31:0] expq[$];
  ////////////////////////////////////////
  hbc_top #(.WAKE_CYCLES(20)) dut_u (.sys_clk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .pwm_in_a(pa), .pwm_in_b(pb), .pwm_in_c(pc), .pwm_in_d(pd),
    .drive_enable_hi_ch1(eh1), .drive_enable_lo_ch1(el1), .drive_enable_hi_ch2(eh2),
    .drive_enable_lo_ch2(el2), .combined_channel_mode(mode), .sleep_req(slp), .fault_det(flt),
    .hs_gate_off_a(ga), .hs_gate_off_b(gb), .bridge_leg_pair_a(la), .bridge_leg_pair_b(lb),
    .slew_rate_a(sa), .slew_rate_b(sb));
  hbc_gate_model gm_u (.sys_clk, .reset, .pair_a(la), .pair_b(lb), .gate_off_a(ga), .gate_off_b(gb));
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  ////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic tally_and_finish();
    if (n_errors == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : tally_and_finish
  task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask : apb
  task automatic rd(input logic [31:0] a, input logic [31:0] exp);
    expq.push_back(exp);
    apb(1'b0, a, 32'h0000_0000);
  endtask : rd
  // legs and slew codes compared n+1 cycles later, as one word
  task automatic legs(input int n, input logic [3:0] exp);
    repeat (n) @(posedge sys_clk);
    expq.push_back({22'h00_0000, xsa, xsb, exp});
    chk <= 1'b1;
    @(posedge sys_clk);
    chk <= 1'b0;
  endtask : legs
  task automatic stim(input int k, input logic on);
    case (k)
      0: el1 <= on;
      1: eh1 <= !on;
      2: flt.isd <= on;
      3: flt.vbat_uv <= on;
      4: flt.vcc_uv <= on;
      default: mode <= !on;
    endcase
  endtask : stim
  ////////////////////////////////////////
  always @(posedge sys_clk) begin
    if ((psel && penable && pready && !pwrite) || chk)
      check(chk ? {22'h00_0000, sa, sb, la, lb} : prdata, expq.pop_front());
  end
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles > 6000) begin
      n_errors++;
      tally_and_finish();
    end
  end
  initial begin
    {psel, penable, pwrite, paddr, pwdata, chk, pa, pb, pc, pd, el1, el2, slp, flt} = '0;
    {eh1, eh2, mode, reset} = 4'hf;
    {n_errors, tests_run, cycles, xsa, xsb} = '0;
    seed = 71;
    repeat (20) @(posedge sys_clk);
    reset <= 1'b0;
    repeat (40) @(posedge sys_clk);
    rd(ADDR_CFG_CH1, 32'h0000_0000);
    for (int c = 0; c < 8; c++) begin
      w = ($random(seed) & 32'hffef_8fff) | (32'(c) << 12);
      apb(1'b1, ADDR_CFG_CH1, w);
      apb(1'b1, ADDR_CFG_CH2, w);
      xsa = (c == 7) ? 3'h0 : 3'(c);
      xsb = xsa;
      rd(ADDR_CFG_CH2, w & CFG_WRITE_MASK);
      legs(1, 4'h5);
    end
    rd(32'h0000_000c, 32'h0000_0000);
    rd(ADDR_STATUS, 32'h0000_0060);
    pa <= 1'b1;
    legs(60, 4'h9);
    pa <= 1'b0;
    legs(15, 4'h5);
    apb(1'b1, ADDR_CFG_CH1, 32'h0010_0000);
    pa <= 1'b1;
    legs(60, 4'h9);
    pa <= 1'b0;
    legs(60, 4'ha);
    repeat (20) begin
      {pc, pd} <= 2'($random(seed));
      @(posedge sys_clk);
    end
    legs(1, 4'ha);
    {pc, pd} <= 2'h0;
    flt.open_load <= 1'b1;
    legs(10, 4'ha);
    flt.open_load <= 1'b0;
    for (int k = 0; k < 6; k++) begin
      stim(k, 1'b1);
      legs(5, (k < 2) ? 4'h2 : 4'h0);
      stim(k, 1'b0);
      legs(70, 4'ha);
    end
    flt.tsd <= 1'b1;
    flt.vbat_uv <= 1'b1;
    legs(5, 4'h0);
    flt.tsd <= 1'b0;
    legs(5, 4'h0);
    flt.vbat_uv <= 1'b0;
    legs(70, 4'h0);
    rd(ADDR_STATUS, 32'h0000_0061);
    apb(1'b1, ADDR_STATUS, 32'h0000_0001);
    rd(ADDR_STATUS, 32'h0000_0060);
    legs(70, 4'ha);
    slp <= 1'b1;
    legs(5, 4'h0);
    slp <= 1'b0;
    legs(12, 4'h0);
    legs(80, 4'ha);
    tally_and_finish();
  end
endmodule : hbridge_output_control_tb_top
`default_nettype wire
